// >>> hdl/ddrmr_pkg.sv
// Shared constants and types for the mode register and burst order block
package ddrmr_pkg;
   localparam int ADDR_W = 13;
   localparam int BA_W = 2;
   localparam int COL_W = 3;
   localparam int HALF_W = 4;
   // Pin bundle: {ck, cke, cs_b, ras_b, cas_b, we_b, ba, addr}
   localparam int PIN_W = ADDR_W + BA_W + 6;
   localparam int PIN_CK = PIN_W - 1;
   localparam int PIN_CKE = PIN_W - 2;
   localparam int PIN_CS = PIN_W - 3;
   localparam int PIN_RAS = PIN_W - 4;
   localparam int PIN_CAS = PIN_W - 5;
   localparam int PIN_WE = PIN_W - 6;
   localparam int PIN_BA_LSB = ADDR_W;
   // Mode register fields
   localparam int BL_LSB = 0;
   localparam int BL_MSB = 2;
   localparam int ORDER_BIT = 3;
   localparam int LAT_LSB = 4;
   localparam int LAT_MSB = 6;
   localparam int TEST_LSB = 7;
   localparam int TEST_MSB = 8;
   // Extended mode register fields
   localparam int EXT_DLL_BIT = 0;
   localparam int EXT_DRIVE_BIT = 1;
   // Bank select bit that picks the target register
   localparam int BA_SEL_BIT = 0;
   localparam logic [2:0] BL_CODE_2 = 3'h1;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [2:0] BL_MASK_2 = 3'h1;
   localparam logic [2:0] BL_MASK_4 = 3'h3;
   localparam logic [2:0] BL_MASK_8 = 3'h7;
   localparam logic [2:0] BL_MASK_NONE = 3'h0;
   localparam logic [2:0] LAT_CODE_2 = 3'h2;
   localparam logic [2:0] LAT_CODE_3 = 3'h3;
   localparam logic [2:0] LAT_CODE_25 = 3'h6;
   // Read latency in link half cycles
   localparam logic [HALF_W-1:0] LAT_HALF_2 = 4'h4;
   localparam logic [HALF_W-1:0] LAT_HALF_3 = 4'h6;
   localparam logic [HALF_W-1:0] LAT_HALF_25 = 4'h5;
   localparam logic [HALF_W-1:0] LAT_HALF_NONE = 4'h0;
   localparam logic [HALF_W-1:0] HALF_ONE = 4'h1;
   localparam logic [1:0] TEST_NORMAL = 2'h0;
   localparam logic [1:0] TEST_DLL_RESET = 2'h2;
   localparam logic [ADDR_W-1:0] REG_RST = 13'h0000;
   localparam logic [COL_W-1:0] COL_ZERO = 3'h0;
   localparam logic [COL_W-1:0] COL_ONE = 3'h1;
   typedef enum logic [1:0] {
      DDRMR_IDLE = 2'b00,
      DDRMR_WAIT = 2'b01,
      DDRMR_BURST = 2'b10
   } ddrmr_state_type;
endpackage

// >>> hdl/ddrmr_burst_seq.sv
// Column of one burst beat for sequential or interleave ordering
`timescale 1ns/1ps
module ddrmr_burst_seq (
   input wire logic [ddrmr_pkg::COL_W-1:0] start_col,
   input wire logic [ddrmr_pkg::COL_W-1:0] len_mask,
   input wire logic interleave,
   input wire logic [ddrmr_pkg::COL_W-1:0] beat_idx,
   output logic [ddrmr_pkg::COL_W-1:0] col
);
   import ddrmr_pkg::*;
   logic [COL_W-1:0] sum_col;
   logic [COL_W-1:0] seq_col;
   logic [COL_W-1:0] intl_col;
   // Wrap inside the aligned block; upper column bits pass untouched
   assign sum_col = start_col + beat_idx;
   assign seq_col = (sum_col & len_mask) | (start_col & ~len_mask);
   assign intl_col = start_col ^ (beat_idx & len_mask);
   assign col = interleave ? intl_col : seq_col;
endmodule

// >>> hdl/ddrmr_top.sv
// Mode and extended mode registers, read latency and burst column order
// How it works
// - Sequential order increments from start column, wrapping in the burst-length block.
// - Interleave order is start column low bits XOR a beat counter.
// - Mode bits 6:4 give read latency 2, 3 or 2.5 clocks.
// - Mode bits 8:7: 00 normal, 10 resets the delay-locked loop.
// - Bank select bit 0 picks mode or extended register; bit 1 reserved.
// - Extended register loads address bits when all command strobes are low and bank bit 0 is high.
// - Registers may be rewritten at any time with banks idle.
// - Extended bit 0 low enables the loop, high disables it.
// - Extended bit 1 low is full drive, high is weak drive.
// - Mode bits 2:0 give burst length 2, 4 or 8.
// - Mode bit 3 low is sequential order, high is interleave.
// - Mode register loads when strobes and bank bit 0 are low.
`timescale 1ns/1ps
module ddrmr_top (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ck,
   input wire logic cke,
   input wire logic cs_b,
   input wire logic ras_b,
   input wire logic cas_b,
   input wire logic we_b,
   input wire logic [ddrmr_pkg::BA_W-1:0] ba,
   input wire logic [ddrmr_pkg::ADDR_W-1:0] addr,
   output logic [ddrmr_pkg::ADDR_W-1:0] mode_reg,
   output logic [ddrmr_pkg::ADDR_W-1:0] ext_mode_reg,
   output logic dll_enable,
   output logic drive_weak,
   output logic dll_reset_pulse,
   output logic mode_reserved,
   output logic [ddrmr_pkg::COL_W-1:0] burst_col,
   output logic beat_valid,
   output logic first_beat
);
   import ddrmr_pkg::*;
   logic [PIN_W-1:0] pin_s1_ff;
   logic [PIN_W-1:0] pin_s2_ff;
   logic ck_s3_ff;
   logic [ADDR_W-1:0] mode_reg_ff;
   logic [ADDR_W-1:0] ext_reg_ff;
   logic dll_reset_ff;
   logic reserved_ff;
   ddrmr_state_type state_ff;
   ddrmr_state_type nxt_state;
   logic [HALF_W-1:0] half_cnt_ff;
   logic [HALF_W-1:0] nxt_half_cnt;
   logic [COL_W-1:0] start_col_ff;
   logic [COL_W-1:0] beat_idx_ff;
   logic [COL_W-1:0] nxt_beat_idx;
   logic [COL_W-1:0] burst_col_ff;
   logic beat_valid_ff;
   logic first_beat_ff;
   logic emit;
   logic emit_first;
   logic [COL_W-1:0] seq_col;

   // Every pin, the link clock too, is synchronised before use
   always_ff @(posedge clk_sys) begin
      pin_s1_ff <= {ck, cke, cs_b, ras_b, cas_b, we_b, ba, addr};
      pin_s2_ff <= pin_s1_ff;
      ck_s3_ff <= pin_s2_ff[PIN_CK];
   end

   // Pins share one delay, so command bits line up with the detected edge
   wire ck_rise = pin_s2_ff[PIN_CK] & ~ck_s3_ff;
   wire ck_fall = ~pin_s2_ff[PIN_CK] & ck_s3_ff;
   wire ck_edge = ck_rise | ck_fall;
   wire [BA_W-1:0] ba_s = pin_s2_ff[PIN_BA_LSB +: BA_W];
   wire [ADDR_W-1:0] addr_s = pin_s2_ff[ADDR_W-1:0];
   wire cmd_ok = ck_rise & pin_s2_ff[PIN_CKE] & ~pin_s2_ff[PIN_CS];
   wire reg_set = cmd_ok & ~pin_s2_ff[PIN_RAS] & ~pin_s2_ff[PIN_CAS] & ~pin_s2_ff[PIN_WE];
   wire rd_cmd = cmd_ok & pin_s2_ff[PIN_RAS] & ~pin_s2_ff[PIN_CAS] & pin_s2_ff[PIN_WE];
   // Bank bit 1 is not decoded, so either value reaches the chosen register
   wire mode_load = reg_set & ~ba_s[BA_SEL_BIT];
   wire ext_load = reg_set & ba_s[BA_SEL_BIT];
   wire dll_rst_cmd = mode_load & (addr_s[TEST_MSB:TEST_LSB] == TEST_DLL_RESET);

   wire [2:0] bl_code = mode_reg_ff[BL_MSB:BL_LSB];
   wire [2:0] lat_code = mode_reg_ff[LAT_MSB:LAT_LSB];
   wire [COL_W-1:0] len_mask = (bl_code == BL_CODE_2) ? BL_MASK_2 :
                               (bl_code == BL_CODE_4) ? BL_MASK_4 :
                               (bl_code == BL_CODE_8) ? BL_MASK_8 : BL_MASK_NONE;
   wire [HALF_W-1:0] lat_half = (lat_code == LAT_CODE_2) ? LAT_HALF_2 :
                                (lat_code == LAT_CODE_3) ? LAT_HALF_3 :
                                (lat_code == LAT_CODE_25) ? LAT_HALF_25 : LAT_HALF_NONE;
   wire test_ok = mode_reg_ff[TEST_MSB:TEST_LSB] == TEST_NORMAL;
   // Reserved burst length or latency codes would give undefined reads, so such reads are dropped
   wire mode_ok = (len_mask != BL_MASK_NONE) & (lat_half != LAT_HALF_NONE);
   wire rd_take = rd_cmd & mode_ok;
   wire interleave = mode_reg_ff[ORDER_BIT];

   // Loads are never gated by bank state; keeping banks idle is the controller's part
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         mode_reg_ff <= REG_RST;
         ext_reg_ff <= REG_RST;
      end else begin
         if (mode_load) begin
            mode_reg_ff <= addr_s;
         end
         if (ext_load) begin
            ext_reg_ff <= addr_s;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         dll_reset_ff <= 1'b0;
         reserved_ff <= 1'b1;
      end else begin
         dll_reset_ff <= dll_rst_cmd;
         reserved_ff <= ~(mode_ok & test_ok);
      end
   end

   ddrmr_burst_seq u_seq (
      .start_col(start_col_ff),
      .len_mask(len_mask),
      .interleave(interleave),
      .beat_idx(beat_idx_ff),
      .col(seq_col)
   );

   // Latency counts link half cycles, so 2.5 lands on a falling edge by itself
   always_comb begin
      nxt_state = state_ff;
      nxt_half_cnt = half_cnt_ff;
      nxt_beat_idx = beat_idx_ff;
      emit = 1'b0;
      emit_first = 1'b0;
      case (state_ff)
         DDRMR_IDLE: begin
         end
         DDRMR_WAIT: begin
            if (ck_edge) begin
               nxt_half_cnt = half_cnt_ff + HALF_ONE;
               if (nxt_half_cnt == lat_half) begin
                  emit = 1'b1;
                  emit_first = 1'b1;
                  nxt_state = DDRMR_BURST;
               end
            end
         end
         DDRMR_BURST: begin
            if (ck_edge) begin
               emit = 1'b1;
            end
         end
         default: begin
            nxt_state = DDRMR_IDLE;
         end
      endcase
      if (emit) begin
         nxt_beat_idx = beat_idx_ff + COL_ONE;
         if (beat_idx_ff == len_mask) begin
            nxt_state = DDRMR_IDLE;
         end
      end
      // A new read interrupts whatever burst is running
      if (rd_take) begin
         nxt_state = DDRMR_WAIT;
         nxt_half_cnt = LAT_HALF_NONE;
         nxt_beat_idx = COL_ZERO;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_ff <= DDRMR_IDLE;
         half_cnt_ff <= LAT_HALF_NONE;
         beat_idx_ff <= COL_ZERO;
         start_col_ff <= COL_ZERO;
      end else begin
         state_ff <= nxt_state;
         half_cnt_ff <= nxt_half_cnt;
         beat_idx_ff <= nxt_beat_idx;
         if (rd_take) begin
            start_col_ff <= addr_s[COL_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         burst_col_ff <= COL_ZERO;
         beat_valid_ff <= 1'b0;
         first_beat_ff <= 1'b0;
      end else begin
         beat_valid_ff <= emit & ~rd_take;
         first_beat_ff <= emit_first & ~rd_take;
         if (emit) begin
            burst_col_ff <= seq_col;
         end
      end
   end

   assign mode_reg = mode_reg_ff;
   assign ext_mode_reg = ext_reg_ff;
   assign dll_enable = ~ext_reg_ff[EXT_DLL_BIT];
   assign drive_weak = ext_reg_ff[EXT_DRIVE_BIT];
   assign dll_reset_pulse = dll_reset_ff;
   assign mode_reserved = reserved_ff;
   assign burst_col = burst_col_ff;
   assign beat_valid = beat_valid_ff;
   assign first_beat = first_beat_ff;

   // Helper logic read only by the checks below
   logic [HALF_W-1:0] hlp_edges_ff;
   logic [COL_W:0] hlp_beats_ff;
   logic hlp_fall_ff;
   always_ff @(posedge clk_sys) begin
      if (!rst_b || rd_take) begin
         hlp_edges_ff <= LAT_HALF_NONE;
         hlp_beats_ff <= '0;
      end else begin
         if (ck_edge && state_ff == DDRMR_WAIT) begin
            hlp_edges_ff <= hlp_edges_ff + HALF_ONE;
         end
         if (beat_valid_ff) begin
            hlp_beats_ff <= hlp_beats_ff + 1'b1;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      hlp_fall_ff <= ck_fall;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence mode_cmd_s;
      reg_set && !ba_s[BA_SEL_BIT];
   endsequence
   sequence ext_cmd_s;
      reg_set && ba_s[BA_SEL_BIT];
   endsequence

   mode_load_a: assert property (mode_cmd_s |=> mode_reg_ff == $past(addr_s))
      else $error("mode register did not load");
   ext_load_a: assert property (ext_cmd_s |=> ext_reg_ff == $past(addr_s))
      else $error("extended register did not load");
   bank_sel_a: assert property (ext_cmd_s |=> $stable(mode_reg_ff))
      else $error("extended write disturbed mode register");
   dll_ctrl_a: assert property (ext_cmd_s |=> dll_enable == !$past(addr_s[EXT_DLL_BIT]))
      else $error("loop enable wrong");
   drive_sel_a: assert property (ext_cmd_s |=> drive_weak == $past(addr_s[EXT_DRIVE_BIT]))
      else $error("drive strength wrong");
   loop_reset_a: assert property (dll_reset_pulse |-> $past(mode_load) &&
      mode_reg_ff[TEST_MSB:TEST_LSB] == TEST_DLL_RESET)
      else $error("loop reset pulse without its code");
   first_data_a: assert property (first_beat |-> hlp_edges_ff == lat_half)
      else $error("first data at wrong latency");
   half_edge_a: assert property (first_beat && lat_code == LAT_CODE_25 |-> hlp_fall_ff)
      else $error("2.5 latency not on falling edge");
   seq_order_a: assert property (first_beat && !interleave |->
      burst_col == start_col_ff)
      else $error("sequential first column wrong");
   intl_order_a: assert property (beat_valid && interleave |->
      ((burst_col ^ start_col_ff) & ~len_mask) == COL_ZERO)
      else $error("interleave left its block");
   burst_len_a: assert property (state_ff == DDRMR_BURST && nxt_state == DDRMR_IDLE && !rd_take
      |=> ##1 hlp_beats_ff == {1'b0, len_mask} + 1'b1)
      else $error("burst length wrong");
endmodule

// >>> verif/ddrmr_ctl_model.sv
// Memory controller model driving the link clock and command pins
`timescale 1ns/1ps
module ddrmr_ctl_model (
   input wire logic clk_sys,
   output logic ck,
   output logic cke,
   output logic cs_b,
   output logic ras_b,
   output logic cas_b,
   output logic we_b,
   output logic [ddrmr_pkg::BA_W-1:0] ba,
   output logic [ddrmr_pkg::ADDR_W-1:0] addr
);
   import ddrmr_pkg::*;
   realtime t_take;
   // No write, activate, refresh or self refresh is issued and no access time is modelled
   // Free running link clock, offset so it never lines up with clk_sys
   initial begin
      ck = 1'h0;
      #7;
      forever #100 ck = ~ck;
   end
   initial begin
      cke = 1'h1;
      {cs_b, ras_b, cas_b, we_b} = 4'hF;
      ba = 2'h0;
      addr = 13'h0000;
      t_take = 0.0;
   end
   // Pins settle just after the falling edge, 82 ns ahead of the sampling rise, and hold after
   task automatic cmd(input logic c_cke, input logic [3:0] c_str,
                      input logic [1:0] c_ba, input logic [12:0] c_addr, input int gap);
      @(negedge ck);
      @(negedge clk_sys);
      cke = c_cke;
      {cs_b, ras_b, cas_b, we_b} = c_str;
      ba = c_ba;
      addr = c_addr;
      @(posedge ck);
      t_take = $realtime;
      @(negedge ck);
      @(negedge clk_sys);
      cke = 1'h1;
      {cs_b, ras_b, cas_b, we_b} = 4'hF;
      // Released lines show the inverse so stale values cannot pass
      ba = ~c_ba;
      addr = ~c_addr;
      repeat (gap) @(posedge ck);
   endtask
endmodule

// >>> verif/ddrmr_top_bench.sv
// Self-checking bench for the mode registers and burst column order
`timescale 1ns/1ps
module ddrmr_top_bench;
   import ddrmr_pkg::*;
   typedef struct {logic [12:0] mode; logic [2:0] start; int bl; int half;} ddrmr_row_type;
   logic clk_sys, rst_b, ck, cke, cs_b, ras_b, cas_b, we_b;
   logic [1:0] ba;
   logic [12:0] addr, mode_reg, ext_mode_reg;
   logic dll_enable, drive_weak, dll_reset_pulse, mode_reserved, beat_valid, first_beat;
   logic [2:0] burst_col;
   logic [2:0] cols[$];
   int n_mismatch = 0;
   int comparisons = 0;
   int n_first, n_dll, cycles;
   realtime t_first;
   ddrmr_row_type rows[6] = '{'{13'h0021, 3'h1, 2, 4}, '{13'h0032, 3'h1, 4, 6},
      '{13'h006A, 3'h3, 4, 5}, '{13'h0023, 3'h5, 8, 4}, '{13'h002B, 3'h6, 8, 4},
      '{13'h003B, 3'h5, 8, 6}};
   ddrmr_ctl_model m (.clk_sys(clk_sys), .ck(ck), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
      .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr));
   ddrmr_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .ck(ck), .cke(cke), .cs_b(cs_b),
      .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr), .mode_reg(mode_reg),
      .ext_mode_reg(ext_mode_reg), .dll_enable(dll_enable), .drive_weak(drive_weak),
      .dll_reset_pulse(dll_reset_pulse), .mode_reserved(mode_reserved),
      .burst_col(burst_col), .beat_valid(beat_valid), .first_beat(first_beat));
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (beat_valid === 1'h1) cols.push_back(burst_col);
      if (first_beat === 1'h1) begin
         n_first++;
         t_first = $realtime;
      end
      if (dll_reset_pulse === 1'h1) n_dll++;
      cycles++;
      // Whole run is a few thousand cycles; this cuts a hang short
      if (cycles == 20000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] seen);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Sync lag puts first data 65 to 120 ns after the ideal link edge
   task automatic chk_t(input string what, input realtime exp, input realtime seen);
      comparisons++;
      if (seen < exp + 65.0 || seen > exp + 120.0) begin
         n_mismatch++;
         $display("mismatch %s expected %0t seen %0t", what, exp, seen);
      end
   endtask
   function automatic logic [2:0] ecol(logic [2:0] s, int bl, logic il, int i);
      logic [2:0] msk;
      msk = 3'(bl - 1);
      if (il) return s ^ 3'(i);
      return (s & ~msk) | (3'(s + 3'(i)) & msk);
   endfunction
   task automatic wr(input logic [1:0] b, input logic [12:0] v);
      m.cmd(1'h1, 4'h0, b, v, 2);
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic burst(input logic [2:0] s, input int bl);
      cols.delete();
      n_first = 0;
      m.cmd(1'h1, 4'h5, 2'h0, {10'h000, s}, 0);
      for (int k = 0; k < 400 && cols.size() < bl; k++) @(posedge clk_sys);
      // Long enough that a wrongly taken read with a reserved latency still shows
      repeat (80) @(posedge clk_sys);
      chk("beats", 13'(bl), 13'(cols.size()));
   endtask
   initial begin
      rst_b = 1'h0;
      cycles = 0;
      n_dll = 0;
      repeat (4) @(posedge clk_sys);
      chk("mode_reg", 13'h0000, mode_reg);
      chk("mode_reserved", 13'h0001, {12'h000, mode_reserved});
      @(negedge clk_sys);
      rst_b = 1'h1;
      repeat (4) @(posedge clk_sys);
      $display("test reset done");
      wr(2'h1, 13'h0000);
      for (int r = 0; r < 6; r++) begin
         wr(2'h0, rows[r].mode);
         chk("mode_reg", rows[r].mode, mode_reg);
         chk("mode_reserved", 13'h0000, {12'h000, mode_reserved});
         burst(rows[r].start, rows[r].bl);
         for (int i = 0; i < rows[r].bl && i < cols.size(); i++)
            chk("burst_col", ecol(rows[r].start, rows[r].bl, rows[r].mode[3], i),
                {10'h000, cols[i]});
         chk("first_beat", 13'h0001, 13'(n_first));
         chk_t("latency", m.t_take + rows[r].half * 100.0, t_first);
         $display("test row %0d done", r);
      end
      wr(2'h1, 13'h0002);
      chk("ext_mode_reg", 13'h0002, ext_mode_reg);
      chk("drive_weak", 13'h0001, {12'h000, drive_weak});
      chk("dll_enable", 13'h0001, {12'h000, dll_enable});
      chk("mode_reg", rows[5].mode, mode_reg);
      wr(2'h3, 13'h0001);
      chk("ext_mode_reg", 13'h0001, ext_mode_reg);
      chk("dll_enable", 13'h0000, {12'h000, dll_enable});
      chk("drive_weak", 13'h0000, {12'h000, drive_weak});
      $display("test extended done");
      n_dll = 0;
      wr(2'h0, 13'h0122);
      chk("dll_reset_pulse", 13'h0001, 13'(n_dll));
      chk("mode_reserved", 13'h0001, {12'h000, mode_reserved});
      // Loop relock time before any later read
      repeat (200) @(posedge ck);
      wr(2'h0, 13'h0022);
      chk("dll_reset_pulse", 13'h0001, 13'(n_dll));
      chk("mode_reserved", 13'h0000, {12'h000, mode_reserved});
      $display("test loop reset done");
      m.cmd(1'h1, 4'h8, 2'h0, 13'h0031, 2);
      m.cmd(1'h0, 4'h0, 2'h0, 13'h0031, 2);
      repeat (2) @(posedge clk_sys);
      chk("mode_reg", 13'h0022, mode_reg);
      $display("test ignored done");
      wr(2'h0, 13'h0024);
      chk("mode_reserved", 13'h0001, {12'h000, mode_reserved});
      burst(3'h0, 0);
      wr(2'h0, 13'h0072);
      chk("mode_reserved", 13'h0001, {12'h000, mode_reserved});
      burst(3'h0, 0);
      $display("test reserved done");
      @(negedge clk_sys);
      rst_b = 1'h0;
      repeat (2) @(posedge clk_sys);
      chk("mode_reg", 13'h0000, mode_reg);
      chk("ext_mode_reg", 13'h0000, ext_mode_reg);
      chk("dll_enable", 13'h0001, {12'h000, dll_enable});
      chk("drive_weak", 13'h0000, {12'h000, drive_weak});
      chk("mode_reserved", 13'h0001, {12'h000, mode_reserved});
      @(negedge clk_sys);
      rst_b = 1'h1;
      repeat (4) @(posedge clk_sys);
      wr(2'h1, 13'h0002);
      chk("drive_weak", 13'h0001, {12'h000, drive_weak});
      chk("dll_enable", 13'h0001, {12'h000, dll_enable});
      $display("test mid reset done");
      results();
   end
endmodule
